// File: hw/vbpc_consts.svh
// Purpose: Offsets, reset values, timing counts and video words.
// Assumes: Included by the self-test block after its package.
// Notes:   Definitions only.
`ifndef VBPC_CONSTS_SVH
`define VBPC_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define VBPC_OFS_CTRL 8'h00
`define VBPC_OFS_STAT 8'h04
`define VBPC_OFS_SIG 8'h08
`define VBPC_CTRL_RST 6'h00
// ----------------------------------------------------------------
// Timing: frame limits in microseconds, clock in MHz
// ----------------------------------------------------------------
`define VBPC_CLK_MHZ 50
`define VBPC_SD525_US 16700
`define VBPC_SD50_US 20000
`define VBPC_SD525_CYC (`VBPC_SD525_US * `VBPC_CLK_MHZ)
`define VBPC_SD50_CYC (`VBPC_SD50_US * `VBPC_CLK_MHZ)
`define VBPC_HD_WORD_KHZ 74250
// ----------------------------------------------------------------
// Video words
// ----------------------------------------------------------------
`define VBPC_W_MAX 10'h3ff
`define VBPC_W_MIN 10'h000
`define VBPC_EAV_ACT 10'h274
`define VBPC_EAV_BLK 10'h2d8
`define VBPC_SAV_ACT 10'h200
`define VBPC_SAV_BLK 10'h2ac
`define VBPC_C_BLK 10'h200
`define VBPC_Y_BLK 10'h040
`define VBPC_EQ_C 10'h300
`define VBPC_EQ_Y 10'h198
`define VBPC_PLL_C 10'h200
`define VBPC_PLL_Y 10'h110
`define VBPC_CRC_POLY 18'h00031
`endif

// File: hw/vbpc_pkg.sv
// Purpose: Types shared by the video self-test block.
// Assumes: Nothing.
// Notes:   Constants live in vbpc_consts.svh.
package vbpc_pkg;
   // One-hot controller states.
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CLEAR = 4'b0010,
      ST_RUN = 4'b0100,
      ST_DONE = 4'b1000
   } vbpc_state_t;
   // Pattern codes.
   typedef enum logic [1:0] {
      PAT_BARS = 2'h0,
      PAT_EQ = 2'h1,
      PAT_PLL = 2'h2,
      PAT_BLACK = 2'h3
   } vbpc_pat_t;
   // Control register fields, top bit first, enable in bit 0.
   typedef struct packed {
      logic rate50;
      logic fmt_hd;
      logic auto_fmt;
      vbpc_pat_t pattern;
      logic enable;
   } vbpc_ctrl_t;
   // Result flags.
   typedef struct packed {
      logic fail;
      logic pass;
      logic done;
   } vbpc_stat_t;
endpackage

// File: hw/vbpc_top.sv
// Purpose: Self-test pattern source and checksum checker for a video link.
// Assumes: One word per clock; register port with read data a cycle later.
// Notes:   Raster sizes are scaled parameters; expected sums are parameters.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "vbpc_consts.svh"
// What this block does
// RL1: Start of test clears scramblers and checkers before commands are taken.
// RL2: While the generator runs, received serial words are ignored.
// RL3: Test starts from pattern code plus enable bit loaded by the host.
// RL4: Format picks pattern type and check: line CRC for HD, EDH for SD.
// RL5: Enable makes generated words replace received data on the path.
// RL6: Words come from stored packets or algorithmic picture samples.
// RL7: Format and sample counters choose source and packet counts per line.
// RL8: Words feed checksums; HD lines carry line number and CRC.
// RL9: Pass only if computed sums equal stored sums at test end.
// RL10: SD test runs one frame within 16.7 ms or 20 ms.
// RL11: SD check keeps separate sums: active, non-video, whole frame.
// RL12: Serializer puts test data on serial output, deserializer parallel.
// RL13: Lines interleave chroma and luma with EAV, SAV, LN and CRC.
// RL14: SD and HD share the path but use distinct checkers.
// RL15: Format is classified automatically and steers generation and check.
// RL16: Parallel path supports word rates up to 74.25 MHz for HD.
// RL17: Four patterns: colour bars, equalizer stress, PLL stress, black.
// RL18: Equalizer stress gives 19 bits one way, then one bit the other.
// RL19: PLL stress gives 20 bits one way, then 20 the other.
// RL20: Done and pass/fail readable, held until a new test starts.
// RL21: Clearing enable stops at the line end and restores normal path.
module vbpc_top #(
   parameter int SD_LINE_W = 64,
   parameter int HD_LINE_W = 128,
   parameter int LINES = 8,
   parameter int VBL = 2,
   parameter int SD525_CYC = `VBPC_SD525_CYC,
   parameter int SD50_CYC = `VBPC_SD50_CYC,
   parameter bit IS_SERIALIZER = 1'b0,
   parameter logic [3:0][17:0] EXP_HD = '0,
   parameter logic [3:0][17:0] EXP_SD_ACT = '0,
   parameter logic [3:0][17:0] EXP_SD_BLK = '0,
   parameter logic [3:0][17:0] EXP_SD_FULL = '0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   // Video words.
   input wire logic [9:0] rx_word,
   output logic [9:0] par_out,
   output logic [9:0] ser_out,
   // Test status.
   output logic path_clear,
   output logic test_done,
   output logic test_pass
);
   localparam int PW = $clog2(HD_LINE_W + 1);
   localparam int LW = $clog2(LINES + 1);
   // A 20 ms frame at 50 MHz needs twenty bits.
   localparam int TW = 20;

   vbpc_pkg::vbpc_state_t st_q, st_d;
   vbpc_pkg::vbpc_ctrl_t ctrl_q, ctrl_d;
   vbpc_pkg::vbpc_stat_t stat_q, stat_d;
   logic [PW-1:0] hpos_q, hpos_d, det_cnt_q, det_cnt_d;
   logic [LW-1:0] vln_q, vln_d;
   logic [TW-1:0] timer_q, timer_d;
   logic [17:0] crc_line_q, crc_line_d, crc_frm_q, crc_frm_d;
   logic [17:0] edh_act_q, edh_act_d, edh_blk_q, edh_blk_d;
   logic run_hd_q, run_hd_d, det_hd_q, det_hd_d;
   logic [9:0] prev1_q, prev2_q, rx_q, out_q, out_d;
   logic [31:0] rdata_q, rdata_d;
   logic [9:0] gen_w;
   logic [PW-1:0] last, act0;
   logic act_line, frame_end, chk_ok;
   logic [2:0] bar;
   logic [TW-1:0] limit;

   // One CRC step per 10-bit word, shared by the line and EDH sums.
   function automatic logic [17:0] crc_step(input logic [17:0] c,
                                            input logic [9:0] w);
      logic [17:0] r;
      logic fb;
      r = c;
      for (int i = 0; i < 10; i++) begin
         fb = r[17] ^ w[i];
         r = {r[16:0], 1'b0} ^ (fb ? `VBPC_CRC_POLY : 18'h00000);
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Raster position and word source
   // ----------------------------------------------------------------
   // The line geometry follows the format latched at test start.
   always_comb begin
      last = run_hd_q ? PW'(HD_LINE_W - 1) : PW'(SD_LINE_W - 1); // [RL7]
      act0 = run_hd_q ? PW'(HD_LINE_W / 4) : PW'(SD_LINE_W / 4);
      act_line = int'(vln_q) >= VBL;
      frame_end = hpos_q == last && int'(vln_q) == LINES - 1;
      limit = ctrl_q.rate50 ? TW'(SD50_CYC) : TW'(SD525_CYC); // [RL10]
      bar = 3'(((int'(hpos_q) - int'(act0)) * 8) /
               (int'(last) + 1 - int'(act0)));
   end

   // Stored packets for timing words, arithmetic for picture samples.
   always_comb begin
      gen_w = hpos_q[0] ? `VBPC_Y_BLK : `VBPC_C_BLK; // [RL6]
      if (hpos_q == 0) begin
         gen_w = `VBPC_W_MAX; // [RL13]
      end else if (hpos_q < 3) begin
         gen_w = `VBPC_W_MIN;
      end else if (hpos_q == 3) begin
         gen_w = act_line ? `VBPC_EAV_ACT : `VBPC_EAV_BLK;
      end else if (run_hd_q && hpos_q < 6) begin
         // Line number word with the inverted top bit. [RL8]
         gen_w = {~vln_q[0], vln_q[0], 8'(vln_q)};
      end else if (run_hd_q && hpos_q == 6) begin
         gen_w = {~crc_line_q[8], crc_line_q[8:0]}; // [RL8] [RL4]
      end else if (run_hd_q && hpos_q == 7) begin
         gen_w = {~crc_line_q[17], crc_line_q[17:9]};
      end else if (hpos_q == act0 - 4) begin
         gen_w = `VBPC_W_MAX;
      end else if (hpos_q > act0 - 4 && hpos_q < act0 - 1) begin
         gen_w = `VBPC_W_MIN;
      end else if (hpos_q == act0 - 1) begin
         gen_w = act_line ? `VBPC_SAV_ACT : `VBPC_SAV_BLK;
      end else if (act_line && hpos_q >= act0) begin
         // Even samples chroma, odd samples luma. [RL13] [RL17]
         unique case (ctrl_q.pattern)
            vbpc_pkg::PAT_BARS: begin
               gen_w = hpos_q[0] ? 10'h2d0 - {1'b0, bar, 6'h00} :
                  (bar[hpos_q[1]] ? 10'h140 : 10'h2c0);
               if (bar == 3'h0 && !hpos_q[0]) begin
                  gen_w = `VBPC_C_BLK;
               end
            end
            vbpc_pkg::PAT_EQ: begin
               gen_w = hpos_q[0] ? `VBPC_EQ_Y : `VBPC_EQ_C; // [RL18]
            end
            vbpc_pkg::PAT_PLL: begin
               gen_w = hpos_q[0] ? `VBPC_PLL_Y : `VBPC_PLL_C; // [RL19]
            end
            vbpc_pkg::PAT_BLACK: begin
               gen_w = hpos_q[0] ? `VBPC_Y_BLK : `VBPC_C_BLK;
            end
         endcase
      end
   end

   // Stored sums are per pattern and per format. [RL9] [RL14]
   // Used on the last, active word; built from _q so no loop forms.
   always_comb begin
      if (run_hd_q) begin
         chk_ok = crc_step(crc_frm_q, gen_w) == EXP_HD[ctrl_q.pattern];
      end else begin
         chk_ok = crc_step(edh_act_q, gen_w) ==
                  EXP_SD_ACT[ctrl_q.pattern] &&
                  edh_blk_q == EXP_SD_BLK[ctrl_q.pattern] &&
                  crc_step(crc_frm_q, gen_w) ==
                  EXP_SD_FULL[ctrl_q.pattern]; // [RL11]
      end
   end

   // ----------------------------------------------------------------
   // Controller, checksums, detector and register port
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      ctrl_d = ctrl_q;
      stat_d = stat_q;
      hpos_d = hpos_q;
      vln_d = vln_q;
      timer_d = timer_q;
      crc_line_d = crc_line_q;
      crc_frm_d = crc_frm_q;
      edh_act_d = edh_act_q;
      edh_blk_d = edh_blk_q;
      run_hd_d = run_hd_q;
      det_hd_d = det_hd_q;
      det_cnt_d = det_cnt_q + 1'b1;
      rdata_d = 32'h00000000;
      if (wr_en && addr == `VBPC_OFS_CTRL) begin
         ctrl_d = vbpc_pkg::vbpc_ctrl_t'(wdata[5:0]); // [RL3]
      end
      if (rd_en) begin
         unique case (addr)
            `VBPC_OFS_CTRL: rdata_d = {26'h0, ctrl_q};
            `VBPC_OFS_STAT: rdata_d = {27'h0, det_hd_q, run_hd_q,
                                       stat_q}; // [RL20]
            `VBPC_OFS_SIG: rdata_d = {14'h0, crc_frm_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
      // Format is learned from the gap between timing words. [RL15]
      if (prev2_q == `VBPC_W_MAX && prev1_q == `VBPC_W_MIN &&
          rx_word == `VBPC_W_MIN && st_q == vbpc_pkg::ST_IDLE) begin
         det_cnt_d = '0;
         if (int'(det_cnt_q) > SD_LINE_W / 2) begin
            det_hd_d = int'(det_cnt_q) > SD_LINE_W;
         end
      end
      if (det_cnt_q == '1) begin
         det_cnt_d = det_cnt_q;
      end
      unique case (st_q)
         vbpc_pkg::ST_IDLE: begin
            if (ctrl_q.enable) begin
               st_d = vbpc_pkg::ST_CLEAR; // [RL3]
            end
         end
         vbpc_pkg::ST_CLEAR: begin
            // Every checker restarts from a known state. [RL1]
            stat_d = '0;
            hpos_d = '0;
            vln_d = '0;
            timer_d = '0;
            crc_line_d = '0;
            crc_frm_d = '0;
            edh_act_d = '0;
            edh_blk_d = '0;
            run_hd_d = ctrl_q.auto_fmt ? det_hd_q : ctrl_q.fmt_hd;
            st_d = vbpc_pkg::ST_RUN;
         end
         vbpc_pkg::ST_RUN: begin
            hpos_d = hpos_q == last ? '0 : hpos_q + 1'b1; // [RL7]
            if (hpos_q == last) begin
               vln_d = vln_q + 1'b1;
            end
            timer_d = timer_q + 1'b1;
            crc_frm_d = crc_step(crc_frm_q, gen_w); // [RL8]
            if (run_hd_q) begin
               if (hpos_q == 7) begin
                  crc_line_d = '0; // [RL4]
               end else if (hpos_q != 6) begin
                  crc_line_d = crc_step(crc_line_q, gen_w);
               end
            end else if (act_line && hpos_q >= act0) begin
               edh_act_d = crc_step(edh_act_q, gen_w); // [RL11]
            end else begin
               edh_blk_d = crc_step(edh_blk_q, gen_w);
            end
            if (!run_hd_q && timer_q == limit) begin
               stat_d = '{fail: 1'b1, pass: 1'b0, done: 1'b1}; // [RL10]
               st_d = vbpc_pkg::ST_DONE;
            end else if (frame_end) begin
               stat_d = '{fail: !chk_ok, pass: chk_ok, done: 1'b1}; // [RL9]
               st_d = vbpc_pkg::ST_DONE;
            end else if (!ctrl_q.enable && hpos_q == last) begin
               st_d = vbpc_pkg::ST_IDLE; // [RL21]
            end
         end
         vbpc_pkg::ST_DONE: begin
            if (!ctrl_q.enable) begin
               st_d = vbpc_pkg::ST_IDLE;
            end
         end
         default: st_d = vbpc_pkg::ST_IDLE;
      endcase
      // Generated words replace received ones while running. [RL2] [RL5]
      out_d = st_q == vbpc_pkg::ST_RUN ? gen_w : rx_word;
   end

   // Registers only; the word path is one cycle deep at any rate. [RL16]
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= vbpc_pkg::ST_IDLE;
         ctrl_q <= vbpc_pkg::vbpc_ctrl_t'(`VBPC_CTRL_RST);
         stat_q <= '0;
         hpos_q <= '0;
         vln_q <= '0;
         timer_q <= '0;
         det_cnt_q <= '0;
         crc_line_q <= '0;
         crc_frm_q <= '0;
         edh_act_q <= '0;
         edh_blk_q <= '0;
         run_hd_q <= 1'b0;
         det_hd_q <= 1'b0;
         prev1_q <= '0;
         prev2_q <= '0;
         rx_q <= '0;
         out_q <= '0;
         rdata_q <= '0;
      end else begin
         st_q <= st_d;
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         hpos_q <= hpos_d;
         vln_q <= vln_d;
         timer_q <= timer_d;
         det_cnt_q <= det_cnt_d;
         crc_line_q <= crc_line_d;
         crc_frm_q <= crc_frm_d;
         edh_act_q <= edh_act_d;
         edh_blk_q <= edh_blk_d;
         run_hd_q <= run_hd_d;
         det_hd_q <= det_hd_d;
         prev1_q <= rx_word;
         prev2_q <= prev1_q;
         rx_q <= rx_word;
         out_q <= out_d;
         rdata_q <= rdata_d;
      end
   end

   // Outputs; the variant decides which side carries test data. [RL12]
   assign par_out = IS_SERIALIZER ? rx_q : out_q;
   assign ser_out = IS_SERIALIZER ? out_q : rx_q;
   assign path_clear = st_q == vbpc_pkg::ST_CLEAR; // [RL1]
   assign test_done = stat_q.done;
   assign test_pass = stat_q.pass;
   assign rdata = rdata_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_CLEAR_FIRST: assert property ( // [RL1]
      st_q == vbpc_pkg::ST_RUN && $past(st_q) != vbpc_pkg::ST_RUN
      |-> $past(st_q) == vbpc_pkg::ST_CLEAR)
      else $error("run entered without a clear cycle");
   AST_START: assert property ( // [RL3]
      st_q == vbpc_pkg::ST_IDLE && ctrl_q.enable
      |=> path_clear ##1 st_q == vbpc_pkg::ST_RUN)
      else $error("enable did not start the test");
   AST_RX_IGNORED: assert property ( // [RL2]
      st_q == vbpc_pkg::ST_RUN |=> out_q == $past(gen_w))
      else $error("received word leaked into test path");
   AST_NORMAL_PATH: assert property ( // [RL21]
      st_q == vbpc_pkg::ST_IDLE |=> out_q == $past(rx_word))
      else $error("normal path not restored");
   AST_STOP_AT_LINE: assert property ( // [RL21]
      st_q == vbpc_pkg::ST_RUN && hpos_q != last &&
      (run_hd_q || timer_q != limit) |=> st_q == vbpc_pkg::ST_RUN)
      else $error("test left run inside a line");
   AST_EAV_SEQ: assert property ( // [RL13]
      st_q == vbpc_pkg::ST_RUN && hpos_q == 0 && !frame_end
      ##1 st_q == vbpc_pkg::ST_RUN
      |-> out_q == `VBPC_W_MAX ##1 out_q == `VBPC_W_MIN)
      else $error("timing preamble wrong");
   AST_HD_CRC: assert property ( // [RL8]
      st_q == vbpc_pkg::ST_RUN && run_hd_q && hpos_q == 6
      |=> out_q[8:0] == $past(crc_line_q[8:0]) && out_q[9] != out_q[8])
      else $error("line CRC word wrong");
   AST_VERDICT: assert property ( // [RL9]
      st_q == vbpc_pkg::ST_RUN && frame_end && !(!run_hd_q &&
      timer_q == limit) |=> test_done && test_pass == $past(chk_ok))
      else $error("verdict does not match sums");
   AST_SD_LIMIT: assert property ( // [RL10]
      st_q == vbpc_pkg::ST_RUN && !run_hd_q |-> timer_q <= limit)
      else $error("SD test overran its frame time");
   AST_HOLD: assert property ( // [RL20]
      st_q == vbpc_pkg::ST_DONE |=> $stable(test_pass) && test_done)
      else $error("result not held");
   AST_FMT: assert property ( // [RL15]
      st_q == vbpc_pkg::ST_CLEAR |=> run_hd_q == ($past(ctrl_q.auto_fmt)
      ? $past(det_hd_q) : $past(ctrl_q.fmt_hd)))
      else $error("format not taken at start");

   COV_PASS: cover property (st_q == vbpc_pkg::ST_RUN ##1 test_pass);
   COV_HD_RUN: cover property (st_q == vbpc_pkg::ST_RUN && run_hd_q);
   COV_STOP: cover property (
      st_q == vbpc_pkg::ST_RUN ##1 st_q == vbpc_pkg::ST_IDLE);
endmodule
`default_nettype wire

// File: sim/vbpc_link_model.sv
// Purpose: Far-side video link that feeds received words to the block.
// Assumes: One word per clock; line length follows the hd input.
// Notes:   Words between preambles walk, so stale data repeats only every 256 clocks.
`timescale 1ns/1ps
`default_nettype none
module vbpc_link_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Line spacing: high selects the long line.
   input wire logic hd,
   // Word toward the block.
   output logic [9:0] rx_word
);
   logic [7:0] pos_q;
   logic [7:0] cnt_q;
   // ----------------------------------------------------------------
   // Raster
   // ----------------------------------------------------------------
   // The line position wraps at the chosen length; the walking count
   // makes any word that the block wrongly passes on easy to spot.
   always_ff @(posedge clk) begin
      cnt_q <= reset ? 8'h00 : cnt_q + 8'h01;
      if (reset || pos_q == (hd ? 8'h7f : 8'h3f)) begin
         pos_q <= 8'h00;
      end else begin
         pos_q <= pos_q + 8'h01;
      end
   end
   // A preamble opens each line so that format detection sees spacing.
   always_comb begin
      if (pos_q == 8'h00) begin
         rx_word = 10'h3ff;
      end else if (pos_q < 8'h03) begin
         rx_word = 10'h000;
      end else begin
         rx_word = {2'h1, cnt_q};
      end
   end
endmodule
`default_nettype wire

// File: sim/tb.sv
// Purpose: Self-checking bench for the video self-test block.
// Assumes: Default expected sums, so every finished test must fail.
// Notes:   Timeouts are shortened by parameter; SD frames are 512 words, HD frames 1024.
`timescale 1ns/1ps
`default_nettype none
`include "vbpc_consts.svh"
module tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic hd_link = 1'b0;
   logic [31:0] rdata;
   logic [9:0] rx_word;
   logic [9:0] par_out;
   logic [9:0] ser_out;
   logic [9:0] rx_prev;
   logic path_clear;
   logic test_done;
   logic test_pass;
   logic [31:0] rv;
   logic [31:0] sig0;
   int n_mismatch = 0;
   int compares = 0;
   // ----------------------------------------------------------------
   // Clock, design and far side
   // ----------------------------------------------------------------
   // The clock toggles every 10 ns, a period of 20 ns.
   always #10 clk = ~clk;
   // Received word one clock late, as the normal path returns it.
   always @(posedge clk) rx_prev <= rx_word;
   vbpc_top #(.SD525_CYC(1000), .SD50_CYC(1200)) dut (
      .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rx_word(rx_word),
      .par_out(par_out), .ser_out(ser_out), .path_clear(path_clear),
      .test_done(test_done), .test_pass(test_pass));
   vbpc_link_model link (.clk(clk), .reset(reset), .hd(hd_link),
      .rx_word(rx_word));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // Comparison with case inequality, so an unknown never matches.
   task automatic check(input string what, input logic [31:0] got,
                        input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Waits one edge and lets its updates settle.
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask
   function automatic logic [31:0] ctl(input logic hd, input logic au,
                                       input logic [1:0] pat);
      return {26'h0, 1'b0, hd, au, pat, 1'b1};
   endfunction
   // Starts a test and checks the clear pulse and the line preamble.
   task automatic start(input logic [31:0] c);
      wr(`VBPC_OFS_CTRL, c);
      step();
      check("path_clear high", {31'h0, path_clear}, 32'h1);
      step();
      check("path_clear low", {31'h0, path_clear}, 32'h0);
      check("done cleared", {31'h0, test_done}, 32'h0);
      step();
      check("word 0", {22'h0, par_out}, {22'h0, `VBPC_W_MAX});
      step();
      check("word 1", {22'h0, par_out}, {22'h0, `VBPC_W_MIN});
      check("serial side", {22'h0, ser_out}, {22'h0, rx_prev});
      step();
      check("word 2", {22'h0, par_out}, {22'h0, `VBPC_W_MIN});
   endtask
   // From word 2, the next line must open at the format's length.
   task automatic line_len(input logic hd);
      repeat (62) step();
      check("start at 64", {31'h0, par_out === `VBPC_W_MAX},
            {31'h0, !hd});
      if (hd) begin
         repeat (64) step();
         check("start at 128", {22'h0, par_out},
               {22'h0, `VBPC_W_MAX});
      end
   endtask
   // Waits for the verdict, checks it, then drops enable.
   task automatic finish_test(input logic hd);
      int i;
      for (i = 0; i < 1200 && test_done !== 1'b1; i++) step();
      check("done", {31'h0, test_done}, 32'h1);
      check("pass", {31'h0, test_pass}, 32'h0);
      rd(`VBPC_OFS_STAT, rv);
      check("status", {28'h0, rv[3:0]}, {28'h0, hd, 3'h5});
      wr(`VBPC_OFS_CTRL, 32'h0);
      step();
      step();
      check("done held", {31'h0, test_done}, 32'h1);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      rd(`VBPC_OFS_CTRL, rv);
      check("ctrl reset", rv, {26'h0, `VBPC_CTRL_RST});
      step();
      check("rdata after", rdata, 32'h0);
      rd(`VBPC_OFS_STAT, rv);
      check("status reset", rv, 32'h0);
      wr(8'h0c, 32'h3f);
      rd(8'h0c, rv);
      check("unmapped", rv, 32'h0);
      rd(`VBPC_OFS_CTRL, rv);
      check("ctrl kept", rv, 32'h0);
      $display("test regs done");
   endtask
   // Every pattern in both formats runs a full frame to a verdict.
   task automatic t_patterns();
      for (int h = 0; h < 2; h++) begin
         for (int p = 0; p < 4; p++) begin
            start(ctl(h[0], 1'b0, p[1:0]));
            line_len(h[0]);
            finish_test(h[0]);
         end
      end
      $display("test patterns done");
   endtask
   // Two bars runs over different received data give one signature.
   task automatic t_ignore_rx();
      start(ctl(1'b0, 1'b0, 2'h0));
      finish_test(1'b0);
      rd(`VBPC_OFS_SIG, sig0);
      repeat (37) step();
      start({26'h0, 6'h21});
      finish_test(1'b0);
      rd(`VBPC_OFS_SIG, rv);
      check("signature", rv, sig0);
      $display("test ignore_rx done");
   endtask
   // Automatic format follows the line spacing that the link shows.
   task automatic t_auto();
      hd_link = 1'b1;
      repeat (300) step();
      start(ctl(1'b0, 1'b1, 2'h3));
      line_len(1'b1);
      finish_test(1'b1);
      rd(`VBPC_OFS_STAT, rv);
      check("detected hd", {31'h0, rv[4]}, 32'h1);
      hd_link = 1'b0;
      repeat (300) step();
      $display("test auto done");
   endtask
   // Dropping enable mid-line returns the received path, no verdict.
   task automatic t_abort();
      start(ctl(1'b0, 1'b0, 2'h1));
      repeat (20) step();
      wr(`VBPC_OFS_CTRL, 32'h0);
      // Word 25 of a blanking line: the test must still be running.
      step();
      check("still running", {22'h0, par_out},
            {22'h0, `VBPC_Y_BLK});
      // The line ends at word 63; only then does the received path return.
      repeat (44) step();
      check("normal path", {22'h0, par_out}, {22'h0, rx_prev});
      check("no verdict", {31'h0, test_done}, 32'h0);
      $display("test abort done");
   endtask
   task automatic give_verdict();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Watchdog: the tests need about ten thousand cycles.
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_patterns();
      t_ignore_rx();
      t_auto();
      t_abort();
      give_verdict();
   end
endmodule
`default_nettype wire
